// File: hw/fmeo_seq.v
// Command sequencer for margin level, data sector erase and override.
// Assumes the array logic runs on the same clock and pulses arr_done
// once per erase or verify request it was given.
`timescale 1ns/1ps
`include "fmeo_regs.vh"
module fmeo_seq #(
   parameter [23:0] PF_LO = 24'h00_0000,
   parameter [23:0] PF_HI = 24'h01_FFFF,
   parameter [23:0] DF_LO = 24'h10_0000,
   parameter [23:0] DF_HI = 24'h10_07FF
) (
   // Clock and reset
   input wire clock,
   input wire rst,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // Operating mode
   input wire mode_allows_cmd,
   // Array control
   output reg arr_erase_req,
   output reg arr_verify_req,
   output reg [23:0] arr_addr,
   input wire arr_done,
   input wire arr_verify_fail,
   input wire arr_verify_uncorr,
   // Read margin levels and bias
   output reg [2:0] pf_margin_q,
   output reg [2:0] df_margin_q,
   output wire pf_bias_erased,
   output wire pf_bias_prog,
   output wire df_bias_erased,
   output wire df_bias_prog,
   // Effective protection
   output wire [7:0] program_protect_setting,
   output wire [7:0] data_protect_setting,
   output wire override_active_bit
);
   localparam S_IDLE = 2'd0;
   localparam S_ERASE = 2'd1;
   localparam S_VERIFY = 2'd2;
   localparam S_DONE = 2'd3;

   reg [1:0] state_q;
   reg [15:0] command_param_words [0:3];
   reg [2:0] param_index_field;
   reg command_complete_flag;
   reg access_error_flag;
   reg protection_violation_flag;
   reg verify_error_bit;
   reg verify_uncorrectable_bit;
   reg ovrd_q;
   reg [7:0] pf_base_q;
   reg [7:0] df_base_q;
   reg [7:0] pf_ovr_q;
   reg [7:0] df_ovr_q;
   reg [15:0] key_q;

   wire setup = psel & ~penable;
   wire wr = psel & penable & pwrite;
   reg hit;
   always @* begin
      case (paddr)
         `FMEO_OFF_STATUS: hit = 1'b1;
         `FMEO_OFF_INDEX: hit = 1'b1;
         `FMEO_OFF_PARAM: hit = 1'b1;
         `FMEO_OFF_PROT: hit = 1'b1;
         `FMEO_OFF_BASE: hit = 1'b1;
         `FMEO_OFF_KEY: hit = 1'b1;
         `FMEO_OFF_MARGIN: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~hit;
   wire wr_ok = wr & hit;

   // Launch is a one written to the complete flag while it is set
   wire launch = wr_ok & (paddr == `FMEO_OFF_STATUS) &
      pwdata[`FMEO_ST_COMMAND_COMPLETE_FLAG] & command_complete_flag;

   // Command decode from the parameter words
   wire [7:0] cmd = command_param_words[0][15:8];
   wire [23:0] gaddr = {command_param_words[0][7:0],
      command_param_words[1]};
   wire [15:0] mg_set = command_param_words[2];
   wire in_pf = (gaddr >= PF_LO) & (gaddr <= PF_HI);
   wire in_df = (gaddr >= DF_LO) & (gaddr <= DF_HI);
   wire is_mg = (cmd == `FMEO_CMD_MARGIN);
   wire is_er = (cmd == `FMEO_CMD_ERASE);
   wire is_ov = (cmd == `FMEO_CMD_OVRD);

   // Protected data region: enable bit set and sector at or below boundary
   wire df_prot_hit = data_protect_setting[`FMEO_PS_EN] &
      (gaddr[10:6] <= data_protect_setting[4:0]);

   // Launch checks, one wire per refusal reason
   wire mg_ix_bad = (param_index_field != `FMEO_IX_MARGIN);
   wire mg_set_bad = (mg_set > `FMEO_MG_MAX);
   wire mg_where_bad = ~mode_allows_cmd | ~(in_pf | in_df);
   wire er_ix_bad = (param_index_field != `FMEO_IX_ERASE);
   wire er_odd = gaddr[0];
   wire er_where_bad = ~mode_allows_cmd | ~in_df;
   wire ov_ix_bad = (param_index_field != `FMEO_IX_OVRD);
   wire mg_bad = mg_ix_bad | mg_set_bad | mg_where_bad;
   wire er_bad = er_ix_bad | er_odd | er_where_bad;

   reg acc_err;
   reg prot_err;
   always @* begin
      acc_err = 1'b0;
      prot_err = 1'b0;
      if (is_mg) begin
         acc_err = mg_bad;
      end else if (is_er) begin
         acc_err = er_bad;
         // Protection is only judged once the access checks pass
         prot_err = ~er_bad & df_prot_hit;
      end else if (is_ov) begin
         acc_err = ov_ix_bad;
      end else begin
         acc_err = 1'b1;
      end
   end
   // A refused launch must not disturb the running state
   wire launch_ok = launch & ~acc_err & ~prot_err;

   // Each block has its own decoder so program reads never follow data
   fmeo_bias_dec #(.W(3)) pf_bias_u (
      .code(pf_margin_q),
      .bias_erased(pf_bias_erased),
      .bias_prog(pf_bias_prog)
   );
   fmeo_bias_dec #(.W(3)) df_bias_u (
      .code(df_margin_q),
      .bias_erased(df_bias_erased),
      .bias_prog(df_bias_prog)
   );

   // Override values stand only while override is active
   assign override_active_bit = ovrd_q;
   assign program_protect_setting = ovrd_q ? pf_ovr_q : pf_base_q;
   assign data_protect_setting = ovrd_q ? df_ovr_q : df_base_q;

   wire status_w = wr_ok & (paddr == `FMEO_OFF_STATUS);
   wire clr_acc = status_w & pwdata[`FMEO_ST_ACC];
   wire clr_pv = status_w & pwdata[`FMEO_ST_PVIOL];
   // Software may not touch parameters while a command runs
   wire param_w = wr_ok & (paddr == `FMEO_OFF_PARAM) &
      command_complete_flag & ~param_index_field[2];

   // Error flags: a set in the same cycle beats a clear
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         access_error_flag <= 1'b0;
         protection_violation_flag <= 1'b0;
      end else begin
         if (launch && acc_err)
            access_error_flag <= 1'b1;
         else if (clr_acc)
            access_error_flag <= 1'b0;
         if (launch && prot_err)
            protection_violation_flag <= 1'b1;
         else if (clr_pv)
            protection_violation_flag <= 1'b0;
      end
   end

   // Read data is captured in the setup cycle and stands to the next one
   reg [31:0] rd_d;
   always @* begin
      rd_d = 32'h0000_0000;
      case (paddr)
         `FMEO_OFF_STATUS:
            rd_d = {24'h00_0000, command_complete_flag, 1'b0,
               access_error_flag, protection_violation_flag,
               2'b00, verify_error_bit, verify_uncorrectable_bit};
         `FMEO_OFF_INDEX:
            rd_d = {29'h0000_0000, param_index_field};
         `FMEO_OFF_PARAM:
            rd_d = param_index_field[2] ? 32'h0000_0000 :
               {16'h0000, command_param_words[param_index_field[1:0]]};
         `FMEO_OFF_PROT:
            rd_d = {8'h00, program_protect_setting, override_active_bit,
               7'h00, data_protect_setting};
         `FMEO_OFF_BASE:
            rd_d = {16'h0000, df_base_q, pf_base_q};
         `FMEO_OFF_KEY:
            rd_d = {16'h0000, key_q};
         `FMEO_OFF_MARGIN:
            rd_d = {21'h00_0000, df_margin_q, 5'h00, pf_margin_q};
         default:
            rd_d = 32'h0000_0000;
      endcase
   end

   integer i;
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         state_q <= S_IDLE;
         for (i = 0; i < 4; i = i + 1)
            command_param_words[i] <= 16'h0000;
         param_index_field <= 3'h0;
         command_complete_flag <= 1'b1;
         verify_error_bit <= 1'b0;
         verify_uncorrectable_bit <= 1'b0;
         ovrd_q <= 1'b0;
         pf_base_q <= `FMEO_RST_PROT;
         df_base_q <= `FMEO_RST_PROT;
         pf_ovr_q <= `FMEO_RST_PROT;
         df_ovr_q <= `FMEO_RST_PROT;
         key_q <= `FMEO_RST_KEY;
         pf_margin_q <= `FMEO_MG_NORMAL;
         df_margin_q <= `FMEO_MG_NORMAL;
         arr_erase_req <= 1'b0;
         arr_verify_req <= 1'b0;
         arr_addr <= 24'h00_0000;
         prdata <= 32'h0000_0000;
      end else begin
         arr_erase_req <= 1'b0;
         arr_verify_req <= 1'b0;
         // Register writes
         if (wr_ok && (paddr == `FMEO_OFF_INDEX) && command_complete_flag)
            param_index_field <= pwdata[2:0];
         if (param_w)
            command_param_words[param_index_field[1:0]] <= pwdata[15:0];
         if (wr_ok && (paddr == `FMEO_OFF_BASE)) begin
            pf_base_q <= pwdata[7:0];
            df_base_q <= pwdata[15:8];
         end
         if (wr_ok && (paddr == `FMEO_OFF_KEY))
            key_q <= pwdata[15:0];
         case (state_q)
            S_IDLE: begin
               if (launch_ok) begin
                  verify_error_bit <= 1'b0;
                  verify_uncorrectable_bit <= 1'b0;
                  command_complete_flag <= 1'b0;
                  if (is_mg) begin
                     if (in_pf) begin
                        pf_margin_q <= mg_set[2:0];
                        df_margin_q <= mg_set[2:0];
                     end else begin
                        df_margin_q <= mg_set[2:0];
                     end
                     state_q <= S_DONE;
                  end else if (is_er) begin
                     arr_addr <= gaddr;
                     arr_erase_req <= 1'b1;
                     state_q <= S_ERASE;
                  end else begin
                     if (command_param_words[1] != `FMEO_KEY_INVALID &&
                        command_param_words[1] == key_q) begin
                        ovrd_q <= 1'b1;
                        pf_ovr_q <= command_param_words[0][0] ?
                           command_param_words[2][7:0] : pf_base_q;
                        df_ovr_q <= command_param_words[0][1] ?
                           command_param_words[3][7:0] : df_base_q;
                     end else begin
                        ovrd_q <= 1'b0;
                     end
                     state_q <= S_DONE;
                  end
               end
               // a refused launch leaves complete flag set
            end
            S_ERASE: begin
               if (arr_done) begin
                  arr_verify_req <= 1'b1;
                  state_q <= S_VERIFY;
               end
            end
            S_VERIFY: begin
               if (arr_done) begin
                  verify_error_bit <= arr_verify_fail |
                     arr_verify_uncorr;
                  verify_uncorrectable_bit <= arr_verify_uncorr;
                  state_q <= S_DONE;
               end
            end
            S_DONE: begin
               command_complete_flag <= 1'b1;
               state_q <= S_IDLE;
            end
            default: state_q <= S_IDLE;
         endcase
         if (setup)
            prdata <= rd_d;
      end
   end
endmodule // fmeo_seq

// Decodes a stored margin code into its read bias
`timescale 1ns/1ps
module fmeo_bias_dec #(
   parameter W = 3
) (
   // Margin code
   input wire [W-1:0] code,
   // Read bias
   output reg bias_erased,
   output reg bias_prog
);
   // Unknown codes cannot be stored, but read as normal level anyway
   always @* begin
      bias_erased = 1'b0;
      bias_prog = 1'b0;
      case (code)
         `FMEO_MG_USER1: bias_erased = 1'b1;
         `FMEO_MG_FIELD1: bias_erased = 1'b1;
         `FMEO_MG_USER0: bias_prog = 1'b1;
         `FMEO_MG_FIELD0: bias_prog = 1'b1;
         default: begin
            bias_erased = 1'b0;
            bias_prog = 1'b0;
         end
      endcase
   end
endmodule // fmeo_bias_dec

// File: shared/fmeo_regs.vh
// Constants of the flash command sequencer: register offsets, fields,
// command codes and reset values.
// Assumes an APB slave with 32-bit data, one register per aligned word.
//
// Notes on behaviour
// - Launched margin command applies the level, then sets command complete.
// - Data block target changes only data block reads.
// - Program block target changes both reads; never program memory alone.
// - Settings 0..4 mean normal, user-1, user-0, field-1, field-0.
// - Margin-1 biases toward erased, margin-0 toward programmed.
// - Margin command flags access error unless index field is 010.
// - Margin setting outside 0..4 flags access error.
// - Mode not permitted or invalid 24-bit address flags access error.
// - Sector erase erases, verifies, then sets command complete.
// - Sector erase flags access error unless index field is 001.
// - Sector erase with odd address flags access error.
// - Erase of a protected data region flags protection violation.
// - Any verify error sets the verify error bit.
// - Uncorrectable verify error sets the uncorrectable bit.
// - Override replaces protection limits only when key matches stored key.
// - Key 0xFFFF is invalid and disables override.
// - A valid but wrong key disables override.
// - Override active state is readable in protection state register.
`ifndef FMEO_REGS_VH
`define FMEO_REGS_VH
// Register byte offsets
`define FMEO_OFF_STATUS 8'h00
`define FMEO_OFF_INDEX 8'h04
`define FMEO_OFF_PARAM 8'h08
`define FMEO_OFF_PROT 8'h0C
`define FMEO_OFF_BASE 8'h10
`define FMEO_OFF_KEY 8'h14
`define FMEO_OFF_MARGIN 8'h18
// Status fields
`define FMEO_ST_COMMAND_COMPLETE_FLAG 7
`define FMEO_ST_ACC 5
`define FMEO_ST_PVIOL 4
`define FMEO_ST_VERR 1
`define FMEO_ST_VUNC 0
// Protection state fields
`define FMEO_PS_OVRD 15
`define FMEO_PS_EN 7
// Command codes
`define FMEO_CMD_MARGIN 8'h0E
`define FMEO_CMD_ERASE 8'h12
`define FMEO_CMD_OVRD 8'h13
// Required index at launch
`define FMEO_IX_MARGIN 3'h2
`define FMEO_IX_ERASE 3'h1
`define FMEO_IX_OVRD 3'h3
// Margin settings and invalid key
`define FMEO_MG_NORMAL 3'h0
`define FMEO_MG_USER1 3'h1
`define FMEO_MG_USER0 3'h2
`define FMEO_MG_FIELD1 3'h3
`define FMEO_MG_FIELD0 3'h4
`define FMEO_MG_MAX 16'h0004
`define FMEO_KEY_INVALID 16'hFFFF
// Reset values
`define FMEO_RST_KEY 16'hFFFF
`define FMEO_RST_PROT 8'h00
`endif

// File: verif/fmeo_arr_model.sv
// Behavioural flash array: answers each erase or verify request.
// Assumes the sequencer clock; the testbench sets the answer delay.
`timescale 1ns/1ps
module fmeo_arr_model (
   // Clock and reset
   input wire clock,
   input wire rst,
   // Requests and answer
   input wire erase_req,
   input wire verify_req,
   input wire [3:0] dly,
   output reg done
);
   reg [4:0] cnt_q;
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         cnt_q <= 5'h00;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (erase_req || verify_req) begin
            cnt_q <= {1'b0, dly} + 5'h01;
         end else if (cnt_q == 5'h01) begin
            done <= 1'b1;
            cnt_q <= 5'h00;
         end else if (cnt_q != 5'h00) begin
            cnt_q <= cnt_q - 5'h01;
         end
      end
   end
endmodule // fmeo_arr_model

// File: verif/fmeo_seq_chk.sv
// Port checker for the flash command sequencer.
// Assumes it is bound to fmeo_seq; one clock, async reset.
`timescale 1ns/1ps
module fmeo_seq_chk #(
   parameter [23:0] DF_LO = 24'h10_0000,
   parameter [23:0] DF_HI = 24'h10_07FF
) (
   // Clock and reset
   input wire clock,
   input wire rst,
   // Array control
   input wire arr_erase_req,
   input wire arr_verify_req,
   input wire [23:0] arr_addr,
   input wire arr_done,
   // Margins
   input wire [2:0] pf_margin_q,
   input wire [2:0] df_margin_q,
   input wire pf_bias_erased,
   input wire pf_bias_prog,
   input wire df_bias_erased,
   input wire df_bias_prog
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   a_verify_after_done: assert property (arr_verify_req |-> $past(arr_done))
      else $error("verify request without erase done");
   a_erase_req_pulse: assert property (arr_erase_req |=> !arr_erase_req
      && !arr_verify_req) else $error("erase request not a pulse");
   a_erase_in_df: assert property (arr_erase_req |-> arr_addr >= DF_LO
      && arr_addr <= DF_HI) else $error("erase outside data block");
   a_erase_even: assert property (arr_erase_req |-> !arr_addr[0])
      else $error("odd erase address");
   a_margin_range: assert property (pf_margin_q <= 3'h4 && df_margin_q <= 3'h4)
      else $error("margin code out of range");
   a_pf_sets_df: assert property ($changed(pf_margin_q) |->
      df_margin_q == pf_margin_q) else $error("program margin alone");
   a_df_bias: assert property (df_bias_erased == (df_margin_q == 3'h1
      || df_margin_q == 3'h3) && df_bias_prog == (df_margin_q == 3'h2
      || df_margin_q == 3'h4)) else $error("data bias decode");
   a_pf_bias: assert property (pf_bias_erased == (pf_margin_q == 3'h1
      || pf_margin_q == 3'h3) && pf_bias_prog == (pf_margin_q == 3'h2
      || pf_margin_q == 3'h4)) else $error("program bias decode");
   c_erase: cover property (arr_erase_req);
   c_verify: cover property (arr_verify_req);
   c_field0: cover property (pf_margin_q == 3'h4);
endmodule // fmeo_seq_chk
bind fmeo_seq fmeo_seq_chk #(.DF_LO(DF_LO), .DF_HI(DF_HI)) chk_u (
   .clock(clock), .rst(rst), .arr_erase_req(arr_erase_req),
   .arr_verify_req(arr_verify_req), .arr_addr(arr_addr), .arr_done(arr_done),
   .pf_margin_q(pf_margin_q), .df_margin_q(df_margin_q),
   .pf_bias_erased(pf_bias_erased), .pf_bias_prog(pf_bias_prog),
   .df_bias_erased(df_bias_erased), .df_bias_prog(df_bias_prog));

// File: verif/testbench.sv
// Self-checking bench for the flash command sequencer over APB.
// Assumes the array model answers requests; mode and verify levels driven.
`timescale 1ns/1ps
`include "fmeo_regs.vh"
module testbench;
   reg clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   reg mode = 1'b1, vf = 1'b0, vu = 1'b0, slv;
   reg [7:0] paddr = 8'h00;
   reg [31:0] pwdata = 32'h0000_0000, q;
   reg [3:0] dly = 4'h0;
   wire [31:0] prdata;
   wire pready, pslverr, erq, vrq, done, pfe, pfp, dfe, dfp, ovr;
   wire [23:0] aad;
   wire [2:0] pfm, dfm;
   wire [7:0] pps, dps;
   integer errors = 0, num_checks = 0, i;
   // Error launches: mode, index, word0, word1, word2
   reg bm [6] = '{1, 1, 1, 1, 1, 0};
   reg [2:0] bx [6] = '{1, 2, 2, 1, 1, 2};
   reg [15:0] b0 [6] = '{16'h0E00, 16'h0E00, 16'h1210, 16'h1210, 16'h1200,
      16'h0E00};
   reg [15:0] b1 [6] = '{0, 0, 16'h0040, 16'h0041, 0, 0};
   reg [15:0] b2 [6] = '{0, 5, 0, 0, 0, 0};
   reg [15:0] ky [4] = '{16'h1234, 16'h5678, 16'h1234, 16'hFFFF};
   reg [31:0] ov [4] = '{32'h0011_8022, 32'h0000_0085, 32'h0011_8022,
      32'h0000_0085};
   reg [31:0] es [3] = '{32'h0000_0082, 32'h0000_0083, 32'h0000_0080};
   fmeo_seq dut_u (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .mode_allows_cmd(mode),
      .arr_erase_req(erq), .arr_verify_req(vrq), .arr_addr(aad),
      .arr_done(done), .arr_verify_fail(vf), .arr_verify_uncorr(vu),
      .pf_margin_q(pfm), .df_margin_q(dfm), .pf_bias_erased(pfe),
      .pf_bias_prog(pfp), .df_bias_erased(dfe), .df_bias_prog(dfp),
      .program_protect_setting(pps), .data_protect_setting(dps),
      .override_active_bit(ovr));
   fmeo_arr_model arr_u (.clock(clock), .rst(rst), .erase_req(erq),
      .verify_req(vrq), .dly(dly), .done(done));
   initial begin
      forever #12.5 clock = ~clock;
   end
   task stop_test;
      begin
         $display("errors %0d checks %0d", errors, num_checks);
         if (errors == 0 && num_checks > 0) $display("Simulation passed");
         else $display("Simulation failed");
         $finish;
      end
   endtask
   task chk(input [31:0] g, input [31:0] e);
      begin
         num_checks = num_checks + 1;
         if (g !== e) begin
            errors = errors + 1;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
         end
      end
   endtask
   // One APB transfer; held until pready is sampled high
   task xf(input w, input [7:0] a, input [31:0] d);
      integer n;
      begin
         @(posedge clock);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge clock);
         penable <= 1'b1;
         n = 0;
         do begin
            @(posedge clock);
            n = n + 1;
         end while (pready !== 1'b1 && n < 50);
         if (n >= 50) begin
            errors = errors + 1;
            stop_test;
         end
         q = prdata;
         slv = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   // Load words 0..ix, leave index at ix, launch, poll for complete
   task cmd(input md, input [2:0] ix, input [15:0] w0, w1, w2, w3);
      reg [15:0] w [4];
      integer j;
      begin
         w = '{w0, w1, w2, w3};
         mode <= md;
         for (j = 0; j <= ix; j = j + 1) begin
            xf(1, `FMEO_OFF_INDEX, j);
            xf(1, `FMEO_OFF_PARAM, {16'h0000, w[j]});
         end
         xf(1, `FMEO_OFF_STATUS, 32'h0000_0080);
         q = 32'h0000_0000;
         for (j = 0; j < 200 && q[7] !== 1'b1; j = j + 1)
            xf(0, `FMEO_OFF_STATUS, 0);
         if (j >= 200) begin
            errors = errors + 1;
            stop_test;
         end
      end
   endtask
   initial begin
      repeat (90000) @(posedge clock);
      errors = errors + 1;
      stop_test;
   end
   initial begin
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      xf(0, `FMEO_OFF_STATUS, 0);
      chk(q, 32'h0000_0080);
      xf(0, `FMEO_OFF_KEY, 0);
      chk(q, 32'h0000_FFFF);
      for (i = 0; i < 5; i = i + 1) begin
         cmd(1, 2, 16'h0E00, 0, i, 0);
         xf(0, `FMEO_OFF_MARGIN, 0);
         chk(q, {21'h0, i[2:0], 5'h0, i[2:0]});
         chk(pfe, i == 1 || i == 3);
         chk(dfp, i == 2 || i == 4);
      end
      cmd(1, 2, 16'h0E10, 0, 1, 0);
      xf(0, `FMEO_OFF_MARGIN, 0);
      chk(q, 32'h0000_0104);
      for (i = 0; i < 6; i = i + 1) begin
         cmd(bm[i], bx[i], b0[i], b1[i], b2[i], 0);
         chk(q, 32'h0000_00A0);
         xf(1, `FMEO_OFF_STATUS, 32'h0000_0030);
         xf(0, `FMEO_OFF_MARGIN, 0);
         chk(q, 32'h0000_0104);
      end
      for (i = 0; i < 3; i = i + 1) begin
         vf <= (i < 2);
         vu <= (i == 1);
         dly <= i * 5;
         cmd(1, 1, 16'h1210, 16'h0040, 0, 0);
         chk(q, es[i]);
         chk(aad, 24'h10_0040);
      end
      // Data protect enabled, region bound 5 covers sector 0
      xf(1, `FMEO_OFF_BASE, 32'h0000_8500);
      cmd(1, 1, 16'h1210, 16'h0000, 0, 0);
      chk(q, 32'h0000_0090);
      xf(1, `FMEO_OFF_STATUS, 32'h0000_0010);
      xf(1, `FMEO_OFF_KEY, 32'h0000_1234);
      for (i = 0; i < 4; i = i + 1) begin
         cmd(1, 3, 16'h1303, ky[i], 16'h0011, 16'h0022);
         xf(0, `FMEO_OFF_PROT, 0);
         chk(q, ov[i]);
         chk(ovr, ov[i][15]);
      end
      xf(0, 8'h1C, 0);
      chk(q, 32'h0000_0000);
      chk(slv, 1);
      stop_test;
   end
endmodule // testbench
